// ==== design/wdc_wakeup_detect.sv ====
// Wake-up detection sequencer with APB register file.
// Assumes the converter result adc_value is produced on pclk and is
// stable by the end of each measurement window.
//
// What this block does
// - Five-bit code trims sense-to-excite parasitic capacitance, 0.1 pF steps.
// - Code set by host register write or by calibrate command.
// - Calibration status and resulting code readable in display register.
// - Wake-up mode entered when only the wake-up bit is set.
// - Roughly 32 kHz RC tick drives configurable wake-up timer.
// - Capacitive, phase and amplitude methods, each selectable.
// - Each period runs each selected measurement and evaluates it.
// - Interrupt when measurement differs from reference beyond threshold.
// - Period selectable 10 ms to 800 ms, 100 ms after reset.
// - Timer control register picks period and enabled methods.
// - Indices 32h to 3Eh hold wake-up configuration and display.
// - Each method owns four consecutive registers from 33h.
// - First register: threshold, reference source, averaging weight.
// - Then host reference, averaged reference, last result.
// - Reference from auto-averaging or from host register.
// - New reference = old - (old - measured) / weight.
// - Averaging arithmetic is 11-bit signed; stored reference is 10 bits.
// - First measurement after reset or set-default seeds average.
// - Per-method bit includes triggering measurement in average.
// - Field on only about 20 us for phase or amplitude.
// - Capacitance measurement takes about 200 us.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module wdc_wakeup_detect #(
  parameter int CAP_CYC = wdc_pkg::CAP_CYC,
  parameter int RC_DIV = wdc_pkg::RC_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter result
  input wire logic [7:0] adc_value,
  // Front-end controls, detection status and interrupt
  output wdc_pkg::wdc_fe_type fe,
  output logic wakeup_active,
  output logic wakeup_irq
);

  // ==========================================================
  // State
  wdc_pkg::wdc_state_type st_q, st_d;
  logic [7:0] op_q, op_d;
  logic [7:0] wtc_q, wtc_d;
  logic [7:0] csc_q, csc_d;
  logic [7:0] csd_q, csd_d;
  logic [7:0] cfg_q [wdc_pkg::N_METH];
  logic [7:0] cfg_d [wdc_pkg::N_METH];
  logic [7:0] ref_q [wdc_pkg::N_METH];
  logic [7:0] ref_d [wdc_pkg::N_METH];
  logic [9:0] avg_q [wdc_pkg::N_METH];
  logic [9:0] avg_d [wdc_pkg::N_METH];
  logic [7:0] res_q [wdc_pkg::N_METH];
  logic [7:0] res_d [wdc_pkg::N_METH];
  logic [wdc_pkg::N_METH-1:0] init_q, init_d;
  logic [wdc_pkg::N_METH:0] irq_q, irq_d;
  logic [1:0] meth_q, meth_d;
  logic [15:0] rc_q, rc_d;
  logic [15:0] tick_q, tick_d;
  logic [15:0] mcnt_q, mcnt_d;
  logic [2:0] cbit_q, cbit_d;
  logic [4:0] cwork_q, cwork_d;
  logic cal_src_q, cal_src_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;

  // ==========================================================
  // Decode helpers
  logic [7:0] idx;
  logic setup, access, wr, rd_irq, wu_req, rc_tick;
  logic in_grp;
  logic [7:0] grp_off;
  logic [1:0] grp_m;
  logic [1:0] grp_r;
  logic [2:0] meth_en;
  logic [15:0] period_ticks;

  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd_irq = access && !pwrite && idx == wdc_pkg::IDX_IRQ;
  assign in_grp = idx >= wdc_pkg::IDX_GRP0 &&
                  idx <= wdc_pkg::IDX_GRP_END;
  assign grp_off = idx - wdc_pkg::IDX_GRP0;
  assign grp_m = grp_off[3:2];
  assign grp_r = grp_off[1:0];
  assign wu_req = op_q == wdc_pkg::OPCTL_WU;
  assign meth_en = wtc_q[wdc_pkg::WTC_EN_LSB +: 3];
  assign rc_tick = rc_q == 16'(RC_DIV - 1);
  // Period in RC ticks; the 32 kHz tolerance carries into the period
  assign period_ticks = 16'(32'(wdc_pkg::period_ms(wtc_q[2:0])) *
                        wdc_pkg::RC_HZ / wdc_pkg::MS_PER_S);

  // First enabled method at or after a given position
  function automatic logic [1:0] next_meth(input logic [2:0] en,
                                           input logic [2:0] from);
    next_meth = wdc_pkg::M_NONE;
    for (int i = wdc_pkg::N_METH - 1; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) begin
        next_meth = 2'(i);
      end
    end
  endfunction : next_meth

  // ==========================================================
  // Evaluation of the current method
  wdc_pkg::wdc_cfg_type cur_cfg;
  logic [7:0] cur_ref, meas, absdiff;
  logic trig;
  logic signed [10:0] dd, step;
  logic [10:0] avg_new;

  always_comb begin
    cur_cfg = wdc_pkg::wdc_cfg_type'(cfg_q[meth_q]);
    meas = res_q[meth_q];
    cur_ref = cur_cfg.auto_ref ? avg_q[meth_q][9:2] : ref_q[meth_q];
    absdiff = meas > cur_ref ? meas - cur_ref : cur_ref - meas;
    // With auto-averaging a seeding measurement is its own reference, so it cannot trigger
    trig = absdiff > {4'h0, cur_cfg.thr} &&
           (init_q[meth_q] || !cur_cfg.auto_ref);
    // Difference stays within old and new, so no overflow in 11 bits
    dd = $signed({1'b0, avg_q[meth_q]}) - $signed({1'b0, meas, 2'b00});
    step = dd >>> cur_cfg.weight_shift;
    avg_new = 11'($signed({1'b0, avg_q[meth_q]}) - step);
  end

  // ==========================================================
  // Next-state logic for registers and sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    wtc_d = wtc_q;
    csc_d = csc_q;
    csd_d = csd_q;
    cfg_d = cfg_q;
    ref_d = ref_q;
    avg_d = avg_q;
    res_d = res_q;
    init_d = init_q;
    irq_d = irq_q;
    meth_d = meth_q;
    rc_d = rc_tick ? 16'h0000 : rc_q + 16'h0001;
    tick_d = tick_q;
    mcnt_d = mcnt_q;
    cbit_d = cbit_q;
    cwork_d = cwork_q;
    cal_src_d = cal_src_q;
    rdata_d = rdata_q;
    err_d = err_q;

    // Read data and error are latched in setup so they come from flops
    if (setup) begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      if (in_grp) begin
        case (grp_r)
          2'h0: rdata_d[7:0] = cfg_q[grp_m];
          2'h1: rdata_d[7:0] = ref_q[grp_m];
          2'h2: rdata_d[7:0] = avg_q[grp_m][9:2];
          default: rdata_d[7:0] = res_q[grp_m];
        endcase
      end else begin
        case (idx)
          wdc_pkg::IDX_OPCTL: rdata_d[7:0] = op_q;
          wdc_pkg::IDX_CSCTL: rdata_d[7:0] = csc_q;
          wdc_pkg::IDX_CSDISP: rdata_d[7:0] = csd_q;
          wdc_pkg::IDX_WTC: rdata_d[7:0] = wtc_q;
          wdc_pkg::IDX_CMD: rdata_d = 32'h0000_0000;
          wdc_pkg::IDX_IRQ: rdata_d[wdc_pkg::N_METH:0] = irq_q;
          default: err_d = 1'b1;
        endcase
      end
    end

    // Register writes; host keeps config still while mode is active
    if (wr && !err_q) begin
      if (in_grp) begin
        case (grp_r)
          2'h0: cfg_d[grp_m] = pwdata[7:0];
          2'h1: ref_d[grp_m] = pwdata[7:0];
          default: ;
        endcase
      end else begin
        case (idx)
          wdc_pkg::IDX_OPCTL: op_d = pwdata[7:0];
          wdc_pkg::IDX_CSCTL: begin
            csc_d = pwdata[7:0];
            cal_src_d = 1'b0;
          end
          wdc_pkg::IDX_WTC: wtc_d = pwdata[7:0];
          wdc_pkg::IDX_CMD: begin
            if (pwdata[7:0] == wdc_pkg::CMD_SET_DEFAULT) begin
              init_d = '0;
              wtc_d = wdc_pkg::WTC_RST;
              for (int i = 0; i < wdc_pkg::N_METH; i++) begin
                cfg_d[i] = wdc_pkg::CFG_RST;
              end
            end
            // Calibration runs only outside wake-up mode
            if (pwdata[7:0] == wdc_pkg::CMD_CALIBRATE &&
                st_q == wdc_pkg::ST_IDLE && !wu_req) begin
              st_d = wdc_pkg::ST_CAL;
              cbit_d = 3'(wdc_pkg::CAL_BITS - 1);
              cwork_d = 5'h10;
              mcnt_d = 16'h0000;
              csd_d = 8'h00;
            end
          end
          default: ;
        endcase
      end
    end

    // Reading the status clears it
    if (rd_irq) begin
      irq_d = '0;
    end

    // Sequencer
    case (st_q)
      wdc_pkg::ST_IDLE: begin
        if (wu_req) begin
          st_d = wdc_pkg::ST_WAIT;
          tick_d = 16'h0000;
        end
      end
      wdc_pkg::ST_WAIT: begin
        if (rc_tick) begin
          tick_d = tick_q + 16'h0001;
        end
        if (rc_tick && tick_q + 16'h0001 >= period_ticks) begin
          tick_d = 16'h0000;
          if (next_meth(meth_en, 3'h0) != wdc_pkg::M_NONE) begin
            meth_d = next_meth(meth_en, 3'h0);
            st_d = wdc_pkg::ST_MEAS;
            mcnt_d = 16'h0000;
          end
        end
      end
      wdc_pkg::ST_MEAS: begin
        mcnt_d = mcnt_q + 16'h0001;
        if ((meth_q == wdc_pkg::M_CAP &&
             mcnt_q == 16'(CAP_CYC - 1)) ||
            (meth_q != wdc_pkg::M_CAP &&
             mcnt_q == 16'(wdc_pkg::FIELD_CYC - 1))) begin
          res_d[meth_q] = adc_value;
          st_d = wdc_pkg::ST_EVAL;
        end
      end
      wdc_pkg::ST_EVAL: begin
        if (!init_q[meth_q]) begin
          avg_d[meth_q] = {meas, 2'b00};
          init_d[meth_q] = 1'b1;
        end else if (!trig || cur_cfg.include_trigger_in_average) begin
          avg_d[meth_q] = avg_new[9:0];
        end
        if (trig) begin
          irq_d[meth_q] = 1'b1;
        end
        mcnt_d = 16'h0000;
        if (next_meth(meth_en, 3'(meth_q) + 3'h1) == wdc_pkg::M_NONE) begin
          st_d = wdc_pkg::ST_WAIT;
        end else begin
          meth_d = next_meth(meth_en, 3'(meth_q) + 3'h1);
          st_d = wdc_pkg::ST_MEAS;
        end
      end
      wdc_pkg::ST_CAL: begin
        mcnt_d = mcnt_q + 16'h0001;
        if (mcnt_q == 16'(CAP_CYC - 1)) begin
          st_d = wdc_pkg::ST_CEVAL;
        end
      end
      wdc_pkg::ST_CEVAL: begin
        // Successive approximation: keep a bit unless the reading is below target
        if (adc_value < wdc_pkg::CAL_TARGET) begin
          cwork_d[cbit_q] = 1'b0;
        end
        mcnt_d = 16'h0000;
        if (cbit_q == 3'h0) begin
          st_d = wdc_pkg::ST_IDLE;
          cal_src_d = 1'b1;
          csd_d = {cwork_d, 1'b0, adc_value > wdc_pkg::CAL_TARGET,
                   1'b1};
          irq_d[wdc_pkg::N_METH] = 1'b1;
        end else begin
          cbit_d = cbit_q - 3'h1;
          cwork_d[cbit_q - 3'h1] = 1'b1;
          st_d = wdc_pkg::ST_CAL;
        end
      end
      default: st_d = wdc_pkg::ST_IDLE;
    endcase

    // Leaving wake-up mode drops any cycle in progress
    if (!wu_req && (st_q == wdc_pkg::ST_WAIT || st_q == wdc_pkg::ST_MEAS ||
                    st_q == wdc_pkg::ST_EVAL)) begin
      st_d = wdc_pkg::ST_IDLE;
    end
  end

  // ==========================================================
  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= wdc_pkg::ST_IDLE;
      op_q <= 8'h00;
      wtc_q <= wdc_pkg::WTC_RST;
      csc_q <= 8'h00;
      csd_q <= 8'h00;
      for (int i = 0; i < wdc_pkg::N_METH; i++) begin
        cfg_q[i] <= wdc_pkg::CFG_RST;
        ref_q[i] <= 8'h00;
        avg_q[i] <= 10'h000;
        res_q[i] <= 8'h00;
      end
      init_q <= '0;
      irq_q <= '0;
      meth_q <= wdc_pkg::M_AMP;
      rc_q <= 16'h0000;
      tick_q <= 16'h0000;
      mcnt_q <= 16'h0000;
      cbit_q <= 3'h0;
      cwork_q <= 5'h00;
      cal_src_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      wtc_q <= wtc_d;
      csc_q <= csc_d;
      csd_q <= csd_d;
      cfg_q <= cfg_d;
      ref_q <= ref_d;
      avg_q <= avg_d;
      res_q <= res_d;
      init_q <= init_d;
      irq_q <= irq_d;
      meth_q <= meth_d;
      rc_q <= rc_d;
      tick_q <= tick_d;
      mcnt_q <= mcnt_d;
      cbit_q <= cbit_d;
      cwork_q <= cwork_d;
      cal_src_q <= cal_src_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // Outputs
  assign pready = access; // One access cycle, read data already held
  assign prdata = rdata_q;
  assign pslverr = access && err_q;
  assign wakeup_active = st_q == wdc_pkg::ST_WAIT ||
                         st_q == wdc_pkg::ST_MEAS ||
                         st_q == wdc_pkg::ST_EVAL;
  assign wakeup_irq = |irq_q;

  // Field only in phase/amplitude windows; electrode held while trimming
  always_comb begin
    fe.antenna_driver_output = st_q == wdc_pkg::ST_MEAS &&
                               meth_q != wdc_pkg::M_CAP;
    fe.cap_excite_electrode = st_q == wdc_pkg::ST_CAL ||
                              st_q == wdc_pkg::ST_CEVAL ||
                              (st_q == wdc_pkg::ST_MEAS &&
                               meth_q == wdc_pkg::M_CAP);
    if (st_q == wdc_pkg::ST_CAL || st_q == wdc_pkg::ST_CEVAL) begin
      fe.cal_code = cwork_q;
    end else if (cal_src_q) begin
      fe.cal_code = csd_q[wdc_pkg::CS_CODE_LSB +: wdc_pkg::CAL_BITS];
    end else begin
      fe.cal_code = csc_q[wdc_pkg::CS_CODE_LSB +: wdc_pkg::CAL_BITS];
    end
  end

endmodule : wdc_wakeup_detect

// ==== design/wdc_pkg.sv ====
// Constants, register map and types of the wake-up detection controller.
// Assumes a 100 MHz APB clock and an 8-bit converter result on that clock.
package wdc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 100_000_000;
  localparam int RC_HZ = 32_000;
  localparam int FIELD_ON_NS = 20_000;
  localparam int CAP_MEAS_NS = 200_000;
  localparam int FIELD_CYC = (FIELD_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAP_CYC = (CAP_MEAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_DIV = CLK_HZ / RC_HZ;
  localparam int MS_PER_S = 1000;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_OPCTL = 8'h02;
  localparam logic [7:0] IDX_CSCTL = 8'h2F;
  localparam logic [7:0] IDX_CSDISP = 8'h30;
  localparam logic [7:0] IDX_WTC = 8'h32;
  localparam logic [7:0] IDX_GRP0 = 8'h33;
  localparam logic [7:0] IDX_GRP_END = 8'h3E;
  localparam logic [7:0] IDX_CMD = 8'h40;
  localparam logic [7:0] IDX_IRQ = 8'h41;

  // ==========================================================
  // Fields and reset values
  localparam logic [7:0] OPCTL_WU = 8'h04;
  localparam logic [7:0] CMD_SET_DEFAULT = 8'h01;
  localparam logic [7:0] CMD_CALIBRATE = 8'h02;
  localparam logic [7:0] WTC_RST = 8'h03;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CAL_TARGET = 8'h80;
  localparam int WTC_EN_LSB = 3;
  localparam int CS_CODE_LSB = 3;
  localparam int CAL_BITS = 5;

  // ==========================================================
  // Methods, in the order they run within one detection cycle
  localparam int N_METH = 3;
  localparam logic [1:0] M_AMP = 2'h0;
  localparam logic [1:0] M_PHASE = 2'h1;
  localparam logic [1:0] M_CAP = 2'h2;
  localparam logic [1:0] M_NONE = 2'h3;

  // Per-method configuration register layout
  typedef struct packed {
    logic [3:0] thr;
    logic auto_ref;
    logic include_trigger_in_average;
    logic [1:0] weight_shift;
  } wdc_cfg_type;

  // Analog front-end controls
  typedef struct packed {
    logic antenna_driver_output;
    logic cap_excite_electrode;
    logic [CAL_BITS-1:0] cal_code;
  } wdc_fe_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_MEAS = 3'b011,
    ST_EVAL = 3'b010,
    ST_CAL = 3'b110,
    ST_CEVAL = 3'b111
  } wdc_state_type;

  // Wake-up period in ms for each select value
  function automatic logic [9:0] period_ms(input logic [2:0] sel);
    case (sel)
      3'h0: period_ms = 10'd10;
      3'h1: period_ms = 10'd20;
      3'h2: period_ms = 10'd50;
      3'h3: period_ms = 10'd100;
      3'h4: period_ms = 10'd200;
      3'h5: period_ms = 10'd300;
      3'h6: period_ms = 10'd400;
      default: period_ms = 10'd800;
    endcase
  endfunction : period_ms

endpackage : wdc_pkg

// ==== sim/wdc_wakeup_detect_chk.sv ====
// Port-level assertions for the wake-up detection controller.
// Assumes it is bound into wdc_wakeup_detect and sees only its ports.
`timescale 1ns/1ps
module wdc_wakeup_detect_chk #(
  parameter int CAP_CYC = 20,
  parameter int RC_DIV = 4
) (
  // Clock, reset and APB
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pslverr,
  // Front end and status
  input wdc_pkg::wdc_fe_type fe,
  input logic wakeup_active,
  input logic wakeup_irq
);
  // ==========================================================
  // Helper state
  logic [15:0] ant_cnt_q, ant_cnt_d, ex_cnt_q, ex_cnt_d;
  logic wu_req_q, wu_req_d, op_wr;

  // On-time counters and whether the last write to operation control was the wake-up value
  always_comb begin
    op_wr = psel && penable && pwrite && paddr[9:2] == wdc_pkg::IDX_OPCTL;
    ant_cnt_d = fe.antenna_driver_output ? ant_cnt_q + 16'h1 : 16'h0;
    ex_cnt_d = fe.cap_excite_electrode ? ex_cnt_q + 16'h1 : 16'h0;
    wu_req_d = op_wr ? (pwdata[7:0] == wdc_pkg::OPCTL_WU) : wu_req_q;
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ant_cnt_q <= 16'h0;
      ex_cnt_q <= 16'h0;
      wu_req_q <= 1'b0;
    end else begin
      ant_cnt_q <= ant_cnt_d;
      ex_cnt_q <= ex_cnt_d;
      wu_req_q <= wu_req_d;
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_field_in_wake;
    fe.antenna_driver_output |-> wakeup_active;
  endproperty
  a_field_in_wake: assert property (p_field_in_wake)
    else $error("field on outside wake-up");
  property p_field_len;
    $fell(fe.antenna_driver_output) |-> ant_cnt_q == wdc_pkg::FIELD_CYC;
  endproperty
  a_field_len: assert property (p_field_len)
    else $error("field pulse length wrong");
  property p_cap_len;
    $fell(fe.cap_excite_electrode) && wakeup_active |-> ex_cnt_q == CAP_CYC;
  endproperty
  a_cap_len: assert property (p_cap_len)
    else $error("capacitance window length wrong");
  property p_one_method;
    !(fe.antenna_driver_output && fe.cap_excite_electrode);
  endproperty
  a_one_method: assert property (p_one_method)
    else $error("two methods at once");
  property p_enter;
    $rose(wakeup_active) |-> wu_req_q && $past(wu_req_q);
  endproperty
  a_enter: assert property (p_enter)
    else $error("wake-up entered without request");
  property p_leave;
    !wu_req_q [*3] |-> !wakeup_active;
  endproperty
  a_leave: assert property (p_leave)
    else $error("wake-up kept without request");
  property p_irq_clear;
    $fell(wakeup_irq) |->
      $past(psel && penable && !pwrite && paddr[9:2] == wdc_pkg::IDX_IRQ);
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt dropped without status read");
  property p_unmapped;
    psel && penable && paddr[9:2] > wdc_pkg::IDX_IRQ |->
      pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  c_enter: cover property ($rose(wakeup_active));
  c_irq: cover property ($rose(wakeup_irq) && wakeup_active);
  c_cap: cover property ($fell(fe.cap_excite_electrode) && wakeup_active);
endmodule : wdc_wakeup_detect_chk

bind wdc_wakeup_detect wdc_wakeup_detect_chk #(.CAP_CYC(CAP_CYC),
  .RC_DIV(RC_DIV)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .fe(fe),
  .wakeup_active(wakeup_active), .wakeup_irq(wakeup_irq));

// ==== sim/wdc_afe_model.sv ====
// Analog front-end stand-in that answers the converter result.
// Assumes the bench sets the scene values; settle delays a valid answer.
`timescale 1ns/1ps
module wdc_afe_model (
  // Clock
  input wire logic pclk,
  // Controls from the controller
  input wire wdc_pkg::wdc_fe_type fe,
  input wire logic wakeup_active,
  // Scene
  input wire logic [7:0] amp_val,
  input wire logic [7:0] cap_val,
  input wire logic [4:0] cal_tgt,
  input wire logic [3:0] settle,
  // Converter result
  output logic [7:0] adc_value
);
  logic [7:0] junk_q = 8'h5A;
  logic [3:0] on_q = 4'h0;

  // Idle output churns so a stale sample never looks right
  always_ff @(posedge pclk) begin
    junk_q <= junk_q + 8'h35;
    if (!(fe.antenna_driver_output || fe.cap_excite_electrode)) begin
      on_q <= 4'h0;
    end else if (on_q != 4'hF) begin
      on_q <= on_q + 4'h1;
    end
  end

  // Answer per active front end; trim above target reads low
  always_comb begin
    if (on_q < settle) begin
      adc_value = junk_q;
    end else if (fe.antenna_driver_output) begin
      adc_value = amp_val;
    end else if (fe.cap_excite_electrode && wakeup_active) begin
      adc_value = cap_val;
    end else if (fe.cap_excite_electrode) begin
      adc_value = (fe.cal_code <= cal_tgt) ? 8'hC0 : 8'h40;
    end else begin
      adc_value = junk_q;
    end
  end
endmodule : wdc_afe_model

// ==== sim/wakeup_detection_controller_test.sv ====
// Self-checking bench for the wake-up detection controller.
// Assumes wdc_afe_model on the converter side; capacitance window and RC divider shortened.
`timescale 1ns/1ps
module wakeup_detection_controller_test;
  localparam int CAP = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic wakeup_active, wakeup_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] adc_value, amp_val, cap_val, rd;
  logic [4:0] cal_tgt;
  logic [3:0] settle;
  wdc_pkg::wdc_fe_type fe;
  int bad_count, n_compared, cnt;

  wdc_wakeup_detect #(.CAP_CYC(CAP), .RC_DIV(4)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_value(adc_value), .fe(fe),
    .wakeup_active(wakeup_active), .wakeup_irq(wakeup_irq));
  wdc_afe_model u_afe (.pclk(pclk), .fe(fe), .wakeup_active(wakeup_active),
    .amp_val(amp_val), .cap_val(cap_val), .cal_tgt(cal_tgt),
    .settle(settle), .adc_value(adc_value));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 20) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rdchk

  function automatic logic sig(input int s);
    case (s)
      0: sig = fe.antenna_driver_output;
      1: sig = fe.cap_excite_electrode;
      2: sig = wakeup_irq;
      default: sig = wakeup_active;
    endcase
  endfunction : sig

  // Counts falling edges, where outputs have settled, until lvl or lim
  task automatic wait_for(input int s, input logic lvl, input int lim);
    cnt = 0;
    do begin
      @(negedge pclk);
      cnt++;
    end while (sig(s) !== lvl && cnt < lim);
    if (sig(s) !== lvl) begin
      bad_count++;
      print_verdict();
    end
  endtask : wait_for

  initial begin
    bad_count = 0;
    n_compared = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    amp_val = 8'h40;
    cap_val = 8'h50;
    cal_tgt = 5'h0B;
    settle = 4'h3;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, refused and read-only places
    rdchk(wdc_pkg::IDX_WTC, wdc_pkg::WTC_RST);
    rdchk(wdc_pkg::IDX_GRP0, wdc_pkg::CFG_RST);
    apb(1'b0, 8'h50, 8'h00);
    check(err, 1'b1);
    wr(8'h35, 8'hAA);
    rdchk(8'h35, 8'h00);
    // Host trim code, then self-calibration while powered down
    wr(wdc_pkg::IDX_CSCTL, 8'h68);
    @(negedge pclk);
    check(fe.cal_code, 5'h0D);
    wr(wdc_pkg::IDX_CMD, wdc_pkg::CMD_CALIBRATE);
    wait_for(2, 1'b1, 400);
    apb(1'b0, wdc_pkg::IDX_CSDISP, 8'h00);
    check(rd & 8'hF9, {cal_tgt, 3'b001});
    check(fe.cal_code, cal_tgt);
    rdchk(wdc_pkg::IDX_IRQ, 8'h08);
    // Wake bit with another bit set must not start detection
    wr(wdc_pkg::IDX_OPCTL, 8'h05);
    repeat (3) @(posedge pclk);
    check(wakeup_active, 1'b0);
    // 10 ms, amplitude on averaged reference, capacitance on host one
    wr(wdc_pkg::IDX_WTC, 8'h28);
    wr(8'h33, 8'h29);
    wr(8'h3B, 8'h30);
    wr(8'h3C, 8'h50);
    wr(wdc_pkg::IDX_OPCTL, wdc_pkg::OPCTL_WU);
    wait_for(0, 1'b1, 3000);
    wait_for(0, 1'b0, 3000);
    check(cnt, wdc_pkg::FIELD_CYC);
    wait_for(1, 1'b1, 5);
    check(cnt < 4, 1'b1);
    wait_for(1, 1'b0, 100);
    check(cnt, CAP);
    repeat (4) @(posedge pclk);
    amp_val <= 8'h48;
    cap_val <= 8'h54;
    check(wakeup_irq, 1'b0);
    rdchk(8'h35, 8'h40);
    rdchk(8'h36, 8'h40);
    rdchk(8'h3E, 8'h50);
    rdchk(8'h3A, 8'h00);
    wait_for(0, 1'b1, 3000);
    check(cnt > 1240 && cnt < 1290, 1'b1);
    // Both triggers have landed once the capacitance window is over
    wait_for(1, 1'b1, 2500);
    wait_for(1, 1'b0, 100);
    check(cnt, CAP);
    rdchk(wdc_pkg::IDX_IRQ, 8'h05);
    rdchk(wdc_pkg::IDX_IRQ, 8'h00);
    rdchk(8'h35, 8'h40);
    rdchk(8'h36, 8'h48);
    // Leave, include triggering results, re-enter on kept average
    wr(wdc_pkg::IDX_OPCTL, 8'h00);
    wait_for(3, 1'b0, 5);
    apb(1'b0, wdc_pkg::IDX_IRQ, 8'h00);
    wr(8'h33, 8'h2D);
    wr(wdc_pkg::IDX_OPCTL, wdc_pkg::OPCTL_WU);
    wait_for(2, 1'b1, 5000);
    rdchk(8'h35, 8'h44);
    // Set-default brings configuration back
    wr(wdc_pkg::IDX_OPCTL, 8'h00);
    wr(wdc_pkg::IDX_CMD, wdc_pkg::CMD_SET_DEFAULT);
    rdchk(wdc_pkg::IDX_WTC, wdc_pkg::WTC_RST);
    rdchk(8'h33, wdc_pkg::CFG_RST);
    print_verdict();
  end
endmodule : wakeup_detection_controller_test
